// ### hw/mdh_params.svh
// Purpose: shared constants for the display host port
// Assumes: ref_clk at 10 MHz
// Notes: strap codes are {protocol_strap_high, protocol_strap_low}
//
// Notes on behaviour
// [RQ1] dc high: byte is display data
// [RQ2] dc low: byte goes to command register
// [RQ3] I2C: dc pin is address low bit
// [RQ4] 6800: rw high reads, low writes
// [RQ5] 8080: rw is write strobe, low
// [RQ6] serial modes: host grounds rw, en
// [RQ7] 6800: en high starts cycle
// [RQ8] 8080: en is read strobe, low
// [RQ9] parallel: eight-bit two-way data bus
// [RQ10] serial: D0 clock, D1 data, D2 open
// [RQ11] I2C: D2/D1 form SDA, D0 SCL
// [RQ12] chip select active low gates cycles
// [RQ13] reset input low initialises device
// [RQ14] straps pick 6800/8080/serial/I2C
// [RQ15] serial: rising clock, MSB first, dc latched
// [RQ16] deselected: ignore strobes, release data
`ifndef MDH_PARAMS_SVH
`define MDH_PARAMS_SVH
// ==========================================================
// protocol straps
`define MDH_STRAP_6800 2'b10
`define MDH_STRAP_8080 2'b11
`define MDH_STRAP_SER  2'b00
`define MDH_STRAP_I2C  2'b01
// ==========================================================
// timing
`define MDH_REF_PERIOD_NS 100
`define MDH_PHASE_NS      800
`define MDH_PHASE_CYC ((`MDH_PHASE_NS + `MDH_REF_PERIOD_NS - 1) / `MDH_REF_PERIOD_NS)
`define MDH_RESET_NS      3000
`define MDH_RESET_CYC ((`MDH_RESET_NS + `MDH_REF_PERIOD_NS - 1) / `MDH_REF_PERIOD_NS)
// ==========================================================
// sequence lengths and I2C framing
`define MDH_PAR_LAST   6'd3
`define MDH_SER_LAST   6'd17
`define MDH_I2C_LAST   6'd59
`define MDH_I2C_ADDR_HI 6'h2a
`define MDH_I2C_SA0    1'b0
`define MDH_CTRL_DC_BIT 6
`endif

// ### hw/mdh_pkg.sv
// Purpose: types for the display host port
// Assumes: mdh_params.svh strap codes
// Notes: none
`include "mdh_params.svh"
package mdh_pkg;
  // ==========================================================
  // protocol modes
  typedef enum logic [1:0] {
    MDH_M6800, MDH_M8080, MDH_SER, MDH_I2C
  } mdh_mode_t;

  function automatic mdh_mode_t mdh_decode(input logic [1:0] straps);
    unique case (straps) // RQ14
      `MDH_STRAP_6800: mdh_decode = MDH_M6800;
      `MDH_STRAP_8080: mdh_decode = MDH_M8080;
      `MDH_STRAP_SER:  mdh_decode = MDH_SER;
      default:         mdh_decode = MDH_I2C;
    endcase
  endfunction : mdh_decode
endpackage : mdh_pkg

// ### hw/mdh_link_if.sv
// Purpose: pins between host and display module
// Assumes: linkClk made by the bench
// Notes: undriven lines pull high; I2C lines are open drain
`timescale 1ns/1ps
`include "mdh_params.svh"
interface mdh_link_if (input wire logic linkClk);
  logic       csN;
  logic       dcSel;
  logic       rwSel;
  logic       enRd;
  logic       reset_n_input;
  logic       protocol_strap_low;
  logic       protocol_strap_high;
  logic [7:0] hostOut;
  logic [7:0] hostOe;
  logic [7:0] devOut;
  logic [7:0] devOe;
  logic [7:0] host_data_lines;
  logic       sdaWire;

  // ==========================================================
  // wire resolution, D2 and D1 tied as SDA in I2C
  assign sdaWire = ~(hostOe[1] & ~hostOut[1]) & ~(devOe[2] & ~devOut[2]);
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      host_data_lines[i] = hostOe[i] ? hostOut[i] :
                           devOe[i] ? devOut[i] : 1'b1;
    end
    if ({protocol_strap_high, protocol_strap_low} == `MDH_STRAP_I2C) begin
      host_data_lines[0] = ~(hostOe[0] & ~hostOut[0]); // RQ11
      host_data_lines[1] = sdaWire;
      host_data_lines[2] = sdaWire;
    end
  end

  modport dev (input linkClk, csN, dcSel, rwSel, enRd, reset_n_input,
               protocol_strap_low, protocol_strap_high, host_data_lines,
               output devOut, devOe);
  modport hst (input host_data_lines,
               output csN, dcSel, rwSel, enRd, reset_n_input,
               protocol_strap_low, protocol_strap_high, hostOut, hostOe);
endinterface : mdh_link_if

// ### hw/mdh_sync.sv
// Purpose: two-flop synchroniser
// Assumes: din is a level from another domain
// Notes: no reset, the stages carry only sampled levels
`timescale 1ns/1ps
module mdh_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;

  if (WIDTH < 1) begin : g_chk
    $error("mdh_sync: WIDTH must be at least 1");
  end

  // ==========================================================
  // first stage is read only by the second
  always_ff @(posedge clk) begin
    stage1 <= din;
    dout   <= stage1;
  end
endmodule : mdh_sync

// ### hw/mdh_device_end.sv
// Purpose: display module end of the multi-protocol host port
// Assumes: linkClk free-running, much faster than host strobes
// Notes: received bytes cross to ref_clk by toggle handshake
`timescale 1ns/1ps
`include "mdh_params.svh"
module mdh_device_end (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  mdh_link_if.dev         lnk,
  input  wire logic [7:0] rdByte,
  input  wire logic       rdLoad,
  output logic      [7:0] rxByte,
  output logic            rxIsData,
  output logic            rxValid
);
  typedef enum logic [2:0] {
    I2C_IDLE, I2C_ADDR, I2C_CTRL, I2C_DATA, I2C_SKIP
  } mdh_i2c_st_t;

  logic [14:0]         pinS;
  logic [7:0]          dS;
  logic                enS;
  logic                rwS;
  logic                dcS;
  logic                sel;
  logic                linkRstN;
  mdh_pkg::mdh_mode_t  mode;
  logic                prevEn;
  logic                prevRw;
  logic                prevScl;
  logic                prevSda;
  logic                sclRise;
  logic                sclFall;
  logic                i2cStart;
  logic                i2cStop;
  logic [6:0]          shiftReg;
  logic [3:0]          bitCnt;
  logic [7:0]          serByte;
  mdh_i2c_st_t         i2cSt;
  logic                i2cDc;
  logic                ackPend;
  logic                ackDrive;
  logic                evtFire;
  logic [7:0]          evtByte;
  logic                evtIsData;
  logic [7:0]          holdByte;
  logic                holdIsData;
  logic                holdTog;
  logic                holdTogS;
  logic                prevHoldTog;
  logic [7:0]          rdReg;
  logic                rdTog;
  logic                rdTogS;
  logic                prevRdTog;
  logic [7:0]          rdLink;
  logic [7:0]          next_devOe;

  // ==========================================================
  // pin capture into the link domain
  mdh_sync #(.WIDTH(15)) pinSync (
    .clk  (lnk.linkClk),
    .din  ({lnk.reset_n_input, lnk.protocol_strap_high,
            lnk.protocol_strap_low, lnk.csN, lnk.dcSel, lnk.rwSel,
            lnk.enRd, lnk.host_data_lines}),
    .dout (pinS)
  );

  // field split of the synchronised pins
  assign dS       = pinS[7:0];
  assign enS      = pinS[8];
  assign rwS      = pinS[9];
  assign dcS      = pinS[10];
  assign sel      = ~pinS[11]; // RQ12
  assign linkRstN = pinS[14];  // RQ13
  assign mode     = mdh_pkg::mdh_decode(pinS[13:12]); // RQ14

  // serial edge and bus condition detection
  assign sclRise  = dS[0] & ~prevScl; // RQ10
  assign sclFall  = ~dS[0] & prevScl;
  assign i2cStart = dS[0] & prevScl & prevSda & ~dS[1];
  assign i2cStop  = dS[0] & prevScl & ~prevSda & dS[1];
  assign serByte  = {shiftReg, dS[1]}; // RQ15

  // ==========================================================
  // previous pin levels for edge detection
  always_ff @(posedge lnk.linkClk) begin
    if (!linkRstN) begin
      prevEn  <= 1'b0;
      prevRw  <= 1'b1;
      prevScl <= 1'b1;
      prevSda <= 1'b1;
    end else begin
      prevEn  <= enS;
      prevRw  <= rwS;
      prevScl <= dS[0];
      prevSda <= dS[1];
    end
  end

  // byte event decode per protocol
  always_comb begin
    evtFire   = 1'b0;
    evtByte   = dS;
    evtIsData = dcS; // RQ1 RQ2
    if (sel) begin // RQ16
      unique case (mode)
        mdh_pkg::MDH_M6800: begin
          // write latched as enable falls, rw low means write
          evtFire = prevEn & ~enS & ~rwS; // RQ4 RQ7
        end
        mdh_pkg::MDH_M8080: begin
          // write strobe releases: data valid throughout the low
          evtFire = ~prevRw & rwS; // RQ5
        end
        mdh_pkg::MDH_SER: begin
          evtFire = sclRise && bitCnt == 4'd7; // RQ15
          evtByte = serByte;
        end
        mdh_pkg::MDH_I2C: begin
          evtFire   = sclRise && bitCnt == 4'd7 && i2cSt == I2C_DATA;
          evtByte   = serByte;
          evtIsData = i2cDc;
        end
      endcase
    end
  end

  // ==========================================================
  // serial shifter shared by clocked serial and I2C
  always_ff @(posedge lnk.linkClk) begin
    if (!linkRstN || !sel) begin
      shiftReg <= 7'h00; // RQ16
      bitCnt   <= 4'h0;
    end else if (mode == mdh_pkg::MDH_I2C && i2cStart) begin
      bitCnt <= 4'h0;
    end else if (sclRise) begin
      shiftReg <= serByte[6:0]; // RQ15
      if (mode == mdh_pkg::MDH_SER) begin
        bitCnt <= (bitCnt == 4'd7) ? 4'h0 : bitCnt + 4'h1;
      end else begin
        // ninth clock is the acknowledge slot
        bitCnt <= (bitCnt == 4'd8) ? 4'h0 : bitCnt + 4'h1;
      end
    end
  end

  // I2C frame state: address, control byte, data stream
  always_ff @(posedge lnk.linkClk) begin
    if (!linkRstN || !sel || mode != mdh_pkg::MDH_I2C) begin
      i2cSt   <= I2C_IDLE;
      i2cDc   <= 1'b0;
      ackPend <= 1'b0;
    end else if (i2cStart) begin
      i2cSt <= I2C_ADDR;
    end else if (i2cStop) begin
      i2cSt <= I2C_IDLE;
    end else if (sclRise && bitCnt == 4'd7) begin
      unique case (i2cSt)
        I2C_ADDR: begin
          // dc pin supplies the address low bit, writes only
          if (serByte == {`MDH_I2C_ADDR_HI, dcS, 1'b0}) begin // RQ3
            i2cSt   <= I2C_CTRL;
            ackPend <= 1'b1;
          end else begin
            i2cSt <= I2C_SKIP;
          end
        end
        I2C_CTRL: begin
          i2cDc   <= serByte[`MDH_CTRL_DC_BIT];
          i2cSt   <= I2C_DATA;
          ackPend <= 1'b1;
        end
        I2C_DATA: ackPend <= 1'b1;
        I2C_IDLE, I2C_SKIP: ;
      endcase
    end else if (sclFall) begin
      ackPend <= 1'b0;
    end
  end

  // acknowledge held low from the falling edge after bit 8 to the next
  always_ff @(posedge lnk.linkClk) begin
    if (!linkRstN || !sel || mode != mdh_pkg::MDH_I2C) begin
      ackDrive <= 1'b0;
    end else if (sclFall) begin
      ackDrive <= ackPend; // RQ11
    end
  end

  // ==========================================================
  // data line drive: read data in parallel, ack on D2 in I2C
  always_comb begin
    next_devOe = 8'h00;
    if (sel) begin // RQ12 RQ16
      unique case (mode)
        mdh_pkg::MDH_M6800: begin
          if (enS && rwS) next_devOe = 8'hff; // RQ4 RQ7 RQ9
        end
        mdh_pkg::MDH_M8080: begin
          if (!enS) next_devOe = 8'hff; // RQ8 RQ9
        end
        mdh_pkg::MDH_SER: next_devOe = 8'h00; // RQ10
        mdh_pkg::MDH_I2C: next_devOe = {5'h00, ackDrive, 2'b00};
      endcase
    end
  end

  always_ff @(posedge lnk.linkClk) begin
    if (!linkRstN) begin
      lnk.devOe  <= 8'h00;
      lnk.devOut <= 8'h00;
    end else begin
      lnk.devOe  <= next_devOe;
      // ack drives D2 low, so only parallel reads carry data
      lnk.devOut <= (mode == mdh_pkg::MDH_I2C) ? 8'h00 : rdLink;
    end
  end

  // ==========================================================
  // received byte held stable, then toggled across
  always_ff @(posedge lnk.linkClk) begin
    if (!linkRstN) begin
      holdByte   <= 8'h00;
      holdIsData <= 1'b0;
      holdTog    <= 1'b0;
    end else if (evtFire) begin
      holdByte   <= evtByte;
      holdIsData <= evtIsData; // RQ1 RQ2
      holdTog    <= ~holdTog;
    end
  end

  // read byte from the user side, taken once its toggle lands
  mdh_sync #(.WIDTH(1)) rdSync (
    .clk  (lnk.linkClk),
    .din  (rdTog),
    .dout (rdTogS)
  );

  always_ff @(posedge lnk.linkClk) begin
    if (!linkRstN) begin
      prevRdTog <= 1'b0;
      rdLink    <= 8'h00;
    end else begin
      prevRdTog <= rdTogS;
      if (rdTogS != prevRdTog) rdLink <= rdReg;
    end
  end

  // ==========================================================
  // user side on ref_clk
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdReg <= 8'h00;
      rdTog <= 1'b0;
    end else if (rdLoad) begin
      rdReg <= rdByte;
      rdTog <= ~rdTog;
    end
  end

  mdh_sync #(.WIDTH(1)) rxSync (
    .clk  (ref_clk),
    .din  (holdTog),
    .dout (holdTogS)
  );

  // one pulse per byte; hold register is stable by now
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prevHoldTog <= 1'b0;
      rxByte      <= 8'h00;
      rxIsData    <= 1'b0;
      rxValid     <= 1'b0;
    end else begin
      prevHoldTog <= holdTogS;
      rxValid     <= holdTogS != prevHoldTog;
      if (holdTogS != prevHoldTog) begin
        rxByte   <= holdByte;
        rxIsData <= holdIsData;
      end
    end
  end
endmodule : mdh_device_end

// ### hw/mdh_host_end.sv
// Purpose: host end driving the display port in any of four modes
// Assumes: straps change only while idle
// Notes: reads are served in the parallel modes only
`timescale 1ns/1ps
`include "mdh_params.svh"
module mdh_host_end #(
  parameter int unsigned PHASE_CYC = `MDH_PHASE_CYC,
  parameter int unsigned RESET_CYC = `MDH_RESET_CYC
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  mdh_link_if.hst         lnk,
  input  wire logic [1:0] modeSel,
  input  wire logic       cmdValid,
  input  wire logic       cmdIsData,
  input  wire logic       cmdIsRead,
  input  wire logic [7:0] cmdByte,
  output logic            cmdReady,
  output logic      [7:0] rspByte,
  output logic            rspValid
);
  typedef enum logic [1:0] {H_RESET, H_IDLE, H_RUN} mdh_host_st_t;

  mdh_host_st_t        state;
  mdh_pkg::mdh_mode_t  mode;
  logic [15:0]         tick;
  logic [5:0]          step;
  logic [5:0]          lastStep;
  logic                stepDone;
  logic                cmdDc;
  logic                cmdRd;
  logic [7:0]          cmdDat;
  logic [7:0]          dSync;
  logic [26:0]         frame;
  logic [5:0]          rel;
  logic                sclL;
  logic                sdaL;
  logic                next_cs;
  logic                next_dc;
  logic                next_rw;
  logic                next_en;
  logic [7:0]          next_out;
  logic [7:0]          next_oe;
  logic [1:0]          next_strap;

  // read data must reach the sampled window: about three link clocks of
  // device latency, so shorter phases return the pull-up level
  if (PHASE_CYC < 6 || PHASE_CYC > 65535 || RESET_CYC < 1 ||
      RESET_CYC > 65535) begin : g_chk
    $error("mdh_host_end: PHASE_CYC 6..65535, RESET_CYC 1..65535");
  end

  mdh_sync #(.WIDTH(8)) dataSync (
    .clk  (ref_clk),
    .din  (lnk.host_data_lines),
    .dout (dSync)
  );

  // pins follow the strap value being loaded, so a new mode never shows
  // the old mode's strobe levels for a cycle
  assign next_strap = (state != H_RUN) ? modeSel :
                      {lnk.protocol_strap_high, lnk.protocol_strap_low};
  assign mode       = mdh_pkg::mdh_decode(next_strap);
  assign stepDone = tick == 16'(PHASE_CYC - 1);
  assign lastStep = (mode == mdh_pkg::MDH_SER) ? `MDH_SER_LAST :
                    (mode == mdh_pkg::MDH_I2C) ? `MDH_I2C_LAST :
                    `MDH_PAR_LAST;
  // address with write bit, control byte, data byte, each with ack slot
  assign frame = {`MDH_I2C_ADDR_HI, `MDH_I2C_SA0, 1'b0, 1'b1,
                  1'b0, cmdDc, 6'h00, 1'b1, cmdDat, 1'b1}; // RQ3 RQ11

  // ==========================================================
  // pin levels for the current step
  always_comb begin
    rel      = step - 6'd2;
    sclL     = 1'b1;
    sdaL     = 1'b1;
    next_cs  = 1'b1;
    next_dc  = cmdDc; // RQ1 RQ2
    next_rw  = mode != mdh_pkg::MDH_SER && mode != mdh_pkg::MDH_I2C;
    next_en  = mode == mdh_pkg::MDH_M8080;
    next_out = 8'h00;
    next_oe  = 8'h00;
    unique case (mode)
      mdh_pkg::MDH_M6800, mdh_pkg::MDH_M8080: begin
        if (state == H_RUN && step < `MDH_PAR_LAST) begin
          next_cs = 1'b0; // RQ12
          if (mode == mdh_pkg::MDH_M6800) begin
            next_rw = cmdRd;        // RQ4
            next_en = step == 6'd1; // RQ7
          end else if (step == 6'd1) begin
            next_en = ~cmdRd; // RQ8
            next_rw = cmdRd;  // RQ5
          end
          if (!cmdRd) begin
            next_out = cmdDat;
            next_oe  = 8'hff; // RQ9
          end
        end
      end
      mdh_pkg::MDH_SER: begin
        // rw and en stay grounded in serial mode
        if (state == H_RUN && step < `MDH_SER_LAST) begin // RQ6
          next_cs = 1'b0;
          next_oe = 8'h03; // RQ10
          if (step != 6'd0) begin
            next_out[0] = ~step[0]; // RQ10
            next_out[1] = cmdDat[3'(6'd7 - ((step - 6'd1) >> 1))]; // RQ15
          end
        end
      end
      mdh_pkg::MDH_I2C: begin
        next_dc = `MDH_I2C_SA0; // RQ3
        if (state == H_RUN && step < `MDH_I2C_LAST) begin
          next_cs = 1'b0;
          if (step == 6'd1) sdaL = 1'b0;
          else if (step >= 6'd2 && step < 6'd56) begin
            sclL = rel[0];
            sdaL = frame[5'(6'd26 - (rel >> 1))];
          end else if (step == 6'd56 || step == 6'd57) begin
            sclL = step[0];
            sdaL = 1'b0;
          end
        end
        // open drain: drive low only
        next_oe = {6'h00, ~sdaL, ~sclL}; // RQ11
      end
    endcase
  end

  // pins registered straight out
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      lnk.csN     <= 1'b1;
      lnk.dcSel   <= 1'b0;
      lnk.rwSel   <= 1'b0;
      lnk.enRd    <= 1'b0;
      lnk.hostOut <= 8'h00;
      lnk.hostOe  <= 8'h00;
    end else begin
      lnk.csN     <= next_cs;
      lnk.dcSel   <= next_dc;
      lnk.rwSel   <= next_rw;
      lnk.enRd    <= next_en;
      lnk.hostOut <= next_out;
      lnk.hostOe  <= next_oe;
    end
  end

  // straps follow modeSel only while no transfer runs
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      lnk.protocol_strap_low  <= 1'b0;
      lnk.protocol_strap_high <= 1'b1;
    end else if (state != H_RUN) begin
      lnk.protocol_strap_low  <= modeSel[0]; // RQ14
      lnk.protocol_strap_high <= modeSel[1];
    end
  end

  // ==========================================================
  // sequencer: reset pulse, then one command per run
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state             <= H_RESET;
      tick              <= 16'h0000;
      step              <= 6'h00;
      cmdReady          <= 1'b0;
      rspValid          <= 1'b0;
      cmdDc             <= 1'b0;
      cmdRd             <= 1'b0;
      cmdDat            <= 8'h00;
      lnk.reset_n_input <= 1'b0; // RQ13
    end else begin
      rspValid <= 1'b0;
      unique case (state)
        H_RESET: begin
          tick <= tick + 16'h0001;
          if (tick == 16'(RESET_CYC - 1)) begin
            tick              <= 16'h0000;
            lnk.reset_n_input <= 1'b1; // RQ13
            state             <= H_IDLE;
            cmdReady          <= 1'b1;
          end
        end
        H_IDLE: begin
          if (cmdValid) begin
            cmdDc    <= cmdIsData;
            // serial modes write only
            cmdRd    <= cmdIsRead && (mode == mdh_pkg::MDH_M6800 ||
                                      mode == mdh_pkg::MDH_M8080);
            cmdDat   <= cmdByte;
            cmdReady <= 1'b0;
            step     <= 6'h00;
            tick     <= 16'h0000;
            state    <= H_RUN;
          end
        end
        H_RUN: begin
          tick <= stepDone ? 16'h0000 : tick + 16'h0001;
          if (stepDone) begin
            if (step == lastStep) begin
              state    <= H_IDLE;
              rspValid <= 1'b1;
              cmdReady <= 1'b1;
            end else begin
              step <= step + 6'h01;
            end
          end
        end
        default: state <= H_RESET;
      endcase
    end
  end

  // read data taken at the end of the strobe phase
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rspByte <= 8'h00;
    end else if (state == H_IDLE && cmdValid) begin
      rspByte <= 8'h00;
    end else if (state == H_RUN && cmdRd && step == 6'd1 && stepDone) begin
      rspByte <= dSync; // RQ9
    end
  end
endmodule : mdh_host_end

// ### verification/mdh_link_sva.sv
// Purpose: link-side checks across host and device ends
// Assumes: straps change only while both ends idle
// Notes: strobe windows allow the device three link clocks to react
`timescale 1ns/1ps
`include "mdh_params.svh"
module mdh_link_sva (
  input wire logic       linkClk,
  input wire logic       csN,
  input wire logic       dcSel,
  input wire logic       rwSel,
  input wire logic       enRd,
  input wire logic       reset_n_input,
  input wire logic       protocol_strap_low,
  input wire logic       protocol_strap_high,
  input wire logic [7:0] devOe,
  input wire logic [7:0] host_data_lines
);
  logic [1:0] strap;
  logic       m68;
  logic       m80;
  logic       ser;
  logic       i2c;
  // ==========================================================
  // mode decode from the straps
  assign strap = {protocol_strap_high, protocol_strap_low};
  assign m68   = strap == `MDH_STRAP_6800;
  assign m80   = strap == `MDH_STRAP_8080;
  assign ser   = strap == `MDH_STRAP_SER;
  assign i2c   = strap == `MDH_STRAP_I2C;
  default clocking cb @(posedge linkClk); endclocking
  default disable iff (!reset_n_input);
  // ==========================================================
  // pin relations
  a_deselect_release: assert property (csN [*6] |-> devOe == 8'h00)
    else $error("device drives data while deselected");
  a_serial_rw_low: assert property ((ser || i2c) |-> !rwSel && !enRd)
    else $error("strobes not grounded in serial mode");
  a_read68_drive: assert property ((m68 && !csN && rwSel && enRd) [*5]
    |-> devOe == 8'hff) else $error("no read drive in 6800 mode");
  a_write68_quiet: assert property ((m68 && !rwSel) [*5]
    |-> devOe == 8'h00) else $error("device drives during 6800 write");
  a_read80_drive: assert property ((m80 && !csN && !enRd) [*5]
    |-> devOe == 8'hff) else $error("no read drive in 8080 mode");
  a_one_strobe80: assert property (m80 && !csN |-> rwSel || enRd)
    else $error("both 8080 strobes low");
  a_serial_no_drive: assert property (ser && !csN |-> devOe == 8'h00)
    else $error("device drives in clocked serial mode");
  a_i2c_sda_only: assert property (i2c |-> devOe[7:3] == 5'h00
    && devOe[1:0] == 2'h0) else $error("device drives a line other than D2");
  a_write_stable: assert property (m68 && !rwSel && $fell(enRd)
    |-> $stable(dcSel) && $stable(host_data_lines))
    else $error("data or dc moved at enable fall");
  c_read68: cover property (m68 && !csN && rwSel && enRd);
  c_read80: cover property (m80 && !csN && !enRd);
  c_i2c_ack: cover property (i2c && devOe[2]);
endmodule : mdh_link_sva

// ### verification/testbench.sv
// Purpose: both ends joined, every mode written and read
// Assumes: short reset count, default phase so read data settles
// Notes: reads in serial modes must come back as zero writes
`timescale 1ns/1ps
`include "mdh_params.svh"
module testbench;
  logic       ref_clk = 1'b0;
  logic       linkClk = 1'b0;
  logic       rst_n = 1'b0;
  logic [1:0] modeSel = `MDH_STRAP_6800;
  logic       cmdValid = 1'b0;
  logic       cmdIsData = 1'b0;
  logic       cmdIsRead = 1'b0;
  logic [7:0] cmdByte = 8'h00;
  logic       cmdReady;
  logic [7:0] rspByte;
  logic       rspValid;
  logic [7:0] rdByte = 8'h00;
  logic       rdLoad = 1'b0;
  logic [7:0] rxByte;
  logic       rxIsData;
  logic       rxValid;
  logic [7:0] rxGot = 8'h00;
  logic [7:0] rxCnt = 8'h00;
  logic       rxD = 1'b0;
  int         err_count = 0;
  int         n_compared = 0;
  int         cyc = 0;
  logic [1:0] modes [4] = '{`MDH_STRAP_6800, `MDH_STRAP_8080,
                            `MDH_STRAP_SER, `MDH_STRAP_I2C};
  logic [7:0] rsp;
  logic [7:0] cnt;
  logic       par;
  // ==========================================================
  // clocks, unrelated periods
  always #50 ref_clk = ~ref_clk;
  always #32 linkClk = ~linkClk;
  mdh_link_if lnk (.linkClk(linkClk));
  mdh_host_end #(.PHASE_CYC(8), .RESET_CYC(4)) mdh_host_end_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .lnk(lnk), .modeSel(modeSel),
    .cmdValid(cmdValid), .cmdIsData(cmdIsData), .cmdIsRead(cmdIsRead),
    .cmdByte(cmdByte), .cmdReady(cmdReady), .rspByte(rspByte),
    .rspValid(rspValid));
  mdh_device_end mdh_device_end_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .lnk(lnk), .rdByte(rdByte),
    .rdLoad(rdLoad), .rxByte(rxByte), .rxIsData(rxIsData),
    .rxValid(rxValid));
  mdh_link_sva mdh_link_sva_inst (
    .linkClk(linkClk), .csN(lnk.csN), .dcSel(lnk.dcSel),
    .rwSel(lnk.rwSel), .enRd(lnk.enRd),
    .reset_n_input(lnk.reset_n_input),
    .protocol_strap_low(lnk.protocol_strap_low),
    .protocol_strap_high(lnk.protocol_strap_high),
    .devOe(lnk.devOe), .host_data_lines(lnk.host_data_lines));
  // ==========================================================
  // received bytes logged; a count catches extra or lost bytes
  always @(posedge ref_clk) begin
    if (rxValid === 1'b1) begin
      rxGot <= rxByte;
      rxD <= rxIsData;
      rxCnt <= rxCnt + 8'h01;
    end
  end
  // hang guard, far above the longest I2C sequence total
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  // one command: hold valid until taken, then wait for the answer
  task automatic send(input logic d, input logic r, input logic [7:0] b,
                      output logic [7:0] rs);
    cmdIsData <= d;
    cmdIsRead <= r;
    cmdByte <= b;
    cmdValid <= 1'b1;
    do @(posedge ref_clk); while (cmdReady !== 1'b1);
    cmdValid <= 1'b0;
    do @(posedge ref_clk); while (rspValid !== 1'b1);
    rs = rspByte;
    repeat (8) @(posedge ref_clk);
  endtask : send
  // ==========================================================
  // main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (12) @(posedge ref_clk);
    chk("rx during reset", rxCnt, 8'h00);
    cnt = 8'h00;
    for (int i = 0; i < 4; i++) begin
      modeSel <= modes[i];
      par = modes[i][1];
      repeat (6) @(posedge ref_clk);
      send(1'b0, 1'b0, 8'h81 ^ 8'(i), rsp);
      cnt = cnt + 8'h01;
      chk("cmd byte", rxGot, 8'h81 ^ 8'(i));
      chk("cmd flag", {7'h00, rxD}, 8'h00);
      send(1'b1, 1'b0, 8'h5a + 8'(i), rsp);
      cnt = cnt + 8'h01;
      chk("data byte", rxGot, 8'h5a + 8'(i));
      chk("data flag", {7'h00, rxD}, 8'h01);
      rdByte <= 8'hc3 - 8'(i);
      rdLoad <= 1'b1;
      @(posedge ref_clk);
      rdLoad <= 1'b0;
      repeat (4) @(posedge ref_clk);
      send(1'b1, 1'b1, 8'h3c, rsp);
      if (!par) cnt = cnt + 8'h01;
      chk("read byte", rsp, par ? 8'hc3 - 8'(i) : 8'h00);
      chk("byte count", rxCnt, cnt);
    end
    tally_and_finish();
  end
endmodule : testbench
